// ---- design/ser_dev.sv ----
`timescale 1ns/1ns
`include "ser_cfg.svh"
module ser_dev #(
  parameter int unsigned WC_CYCLES = `SER_TWC_CYCLES
) (
  input logic core_clk,
  input logic reset_n,
  ser_if.dev link,
  output logic write_busy
);
  import ser_pkg::*;

  logic frame_rst_n;
  ser_dev_state_t state_reg;
  ser_dev_state_t state_next;
  logic [2:0] bitcnt_reg;
  logic [6:0] shift_reg;
  ser_byte_t instr_reg;
  ser_byte_t instr_next;
  ser_addr_t ptr_reg;
  ser_addr_t ptr_next;
  ser_byte_t tx_reg;
  ser_byte_t tx_next;
  ser_byte_t mem [`SER_MEM_DEPTH];
  logic armed_reg;
  ser_addr_t pend_addr_reg;
  ser_byte_t pend_data_reg;
  logic done_seen_reg;
  logic busy_s;
  logic done_s;
  logic sel_s;
  logic sel_prev_reg;
  logic armed_s;
  logic busy_reg;
  logic done_tgl_reg;
  logic [31:0] timer_reg;
  logic so_out_reg;
  logic so_oe_reg;

  // Selection acts as the frame reset, so only the pending write byte, the array and the core-side write cycle survive an aborted frame.
  assign frame_rst_n = reset_n & ~link.cs_n;

  ser_byte_t rx_byte;
  ser_addr_t rx_addr;
  logic byte_done;
  logic wr_byte_done;
  logic commit;
  logic wc_start;
  logic drive_next;

  assign rx_byte = {shift_reg, link.si};
  assign rx_addr = rx_byte[`SER_ADDR_W-1:0];
  assign byte_done = bitcnt_reg == `SER_BYTE_LAST;
  assign wr_byte_done = (state_reg == ST_WRITE) && byte_done;
  assign commit = done_s != done_seen_reg;
  // Selection is synchronised in its active sense, so the reset value matches idle and no false edge follows reset.
  assign wc_start = ~sel_s & sel_prev_reg & armed_s & ~busy_reg;
  assign drive_next = (state_reg == ST_READ) && link.hold_n;

  always_comb begin
    state_next = state_reg;
    instr_next = instr_reg;
    ptr_next = ptr_reg;
    tx_next = tx_reg;
    if (byte_done) begin
      case (state_reg)
        ST_CMD: begin
          instr_next = rx_byte;
          if (ser_cmd_is(rx_byte, `SER_CMD_READ)) begin
            state_next = ST_ADDR_RD;
          end else if (ser_cmd_is(rx_byte, `SER_CMD_WRITE)) begin
            state_next = ST_ADDR_WR;
          end else begin
            state_next = ST_IGNORE;
          end
        end
        ST_ADDR_RD: begin
          if (busy_s) begin
            state_next = ST_IGNORE;
          end else begin
            state_next = ST_READ;
            tx_next = mem[rx_addr];
            ptr_next = rx_addr + `SER_ADDR_STEP;
          end
        end
        ST_ADDR_WR: begin
          if (busy_s) begin
            state_next = ST_IGNORE;
          end else begin
            state_next = ST_WRITE;
            ptr_next = rx_addr;
          end
        end
        ST_READ: begin
          tx_next = mem[ptr_reg];
          // The seven-bit pointer rolls from the top location to zero by itself.
          ptr_next = ptr_reg + `SER_ADDR_STEP;
        end
        ST_WRITE: begin
          ptr_next = ptr_reg + `SER_ADDR_STEP;
        end
        default: begin
          state_next = ST_IGNORE;
        end
      endcase
    end
  end

  // Every bit is taken on the rising clock, and only while hold is released.
  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_reg <= ST_CMD;
      bitcnt_reg <= `SER_BIT_FIRST;
      shift_reg <= 7'h00;
      instr_reg <= 8'h00;
      ptr_reg <= 7'h00;
      tx_reg <= 8'h00;
    end else if (link.hold_n) begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_reg + `SER_BIT_STEP;
      shift_reg <= rx_byte[6:0];
      instr_reg <= instr_next;
      ptr_reg <= ptr_next;
      tx_reg <= tx_next;
    end
  end

  // The pending byte must outlive the frame, so only the global reset clears it.
  always_ff @(posedge link.sck or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'h0;
      pend_addr_reg <= 7'h00;
      pend_data_reg <= 8'h00;
      done_seen_reg <= 1'h0;
    end else begin
      if (commit) begin
        done_seen_reg <= done_s;
      end
      if (link.hold_n) begin
        armed_reg <= wr_byte_done;
        if (wr_byte_done) begin
          pend_addr_reg <= ptr_reg;
          pend_data_reg <= rx_byte;
        end
      end
    end
  end

  // Programming lands on the first link clock edge after the done toggle clears the synchroniser.
  always_ff @(posedge link.sck) begin
    if (commit) begin
      mem[pend_addr_reg] <= pend_data_reg;
    end
  end

  // Output changes on the falling clock so it is settled before the host samples.
  always_ff @(negedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_out_reg <= 1'h0;
      so_oe_reg <= 1'h0;
    end else begin
      so_oe_reg <= drive_next;
      so_out_reg <= tx_reg[`SER_BYTE_LAST - bitcnt_reg];
    end
  end

  assign link.so_out = so_out_reg;
  assign link.so_oe = so_oe_reg;

  ser_sync3 u_busy_sync (
    .clk(link.sck),
    .reset_n(reset_n),
    .din(busy_reg),
    .dout(busy_s)
  );

  ser_sync3 u_done_sync (
    .clk(link.sck),
    .reset_n(reset_n),
    .din(done_tgl_reg),
    .dout(done_s)
  );

  ser_sync3 u_cs_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .din(~link.cs_n),
    .dout(sel_s)
  );

  ser_sync3 u_armed_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .din(armed_reg),
    .dout(armed_s)
  );

  // The done toggle leads the busy drop by one cycle so a read never sees stale data.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_prev_reg <= 1'h0;
      busy_reg <= 1'h0;
      done_tgl_reg <= 1'h0;
      timer_reg <= `SER_TIMER_END;
    end else begin
      sel_prev_reg <= sel_s;
      if (wc_start) begin
        busy_reg <= 1'h1;
        timer_reg <= WC_CYCLES - 32'h1;
      end else if (busy_reg) begin
        timer_reg <= timer_reg - 32'h1;
        if (timer_reg == `SER_TIMER_DONE) begin
          done_tgl_reg <= ~done_tgl_reg;
        end
        if (timer_reg == `SER_TIMER_END) begin
          busy_reg <= 1'h0;
        end
      end
    end
  end

  assign write_busy = busy_reg;
endmodule

// ---- inc/ser_cfg.svh ----
`ifndef SER_CFG_SVH
`define SER_CFG_SVH
`define SER_CMD_READ 8'h03
`define SER_CMD_WRITE 8'h02
`define SER_CMD_MASK 8'hF7
`define SER_IDLE_BYTE 8'h00
`define SER_ADDR_W 7
`define SER_MEM_DEPTH 128
`define SER_BIT_FIRST 3'h0
`define SER_BIT_STEP 3'h1
`define SER_BYTE_LAST 3'h7
`define SER_ADDR_STEP 7'h01
`define SER_TWC_MS 5
`define SER_CORE_HZ 10000000
`define SER_MS_PER_S 1000
`define SER_TWC_CYCLES (`SER_TWC_MS * `SER_CORE_HZ / `SER_MS_PER_S)
`define SER_TIMER_DONE 32'h1
`define SER_TIMER_END 32'h0
`define SER_HALF_DIV 4
`define SER_CS_HIGH_CYCLES 8
`endif

// ---- inc/ser_pkg.sv ----
`include "ser_cfg.svh"
package ser_pkg;
  typedef logic [7:0] ser_byte_t;
  typedef logic [`SER_ADDR_W-1:0] ser_addr_t;
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR_RD,
    ST_ADDR_WR,
    ST_READ,
    ST_WRITE,
    ST_IGNORE
  } ser_dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE,
    H_SHIFT,
    H_END
  } ser_host_state_t;
  typedef enum logic [1:0] {
    PH_INSTR,
    PH_ADDR,
    PH_DATA
  } ser_phase_t;

  function automatic logic ser_cmd_is(input ser_byte_t b, input ser_byte_t cmd);
    return (b & `SER_CMD_MASK) == (cmd & `SER_CMD_MASK);
  endfunction
endpackage

// ---- inc/ser_if.sv ----
`timescale 1ns/1ns
interface ser_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so_out;
  logic so_oe;
  logic so;

  // Released output is modelled as a pull-up so the host never samples an unknown level.
  assign so = so_oe ? so_out : 1'h1;

  modport dev (
    input cs_n,
    input sck,
    input si,
    input hold_n,
    output so_out,
    output so_oe
  );
  modport host (
    output cs_n,
    output sck,
    output si,
    output hold_n,
    input so
  );
endinterface

// ---- design/ser_sync3.sv ----
`timescale 1ns/1ns
module ser_sync3 (
  input logic clk,
  input logic reset_n,
  input logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
      out_reg <= 1'h0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        out_reg <= s3_reg;
      end
    end
  end

  assign dout = out_reg;
endmodule

// ---- design/ser_host.sv ----
`timescale 1ns/1ns
`include "ser_cfg.svh"
module ser_host #(
  parameter int unsigned HALF_DIV = `SER_HALF_DIV,
  parameter int unsigned CS_HIGH = `SER_CS_HIGH_CYCLES
) (
  input logic core_clk,
  input logic reset_n,
  ser_if.host link,
  input logic req_valid,
  input logic req_write,
  input ser_pkg::ser_byte_t req_addr,
  input logic [7:0] req_len,
  input ser_pkg::ser_byte_t wr_data,
  input logic hold_req,
  output logic busy,
  output logic wr_take,
  output ser_pkg::ser_byte_t rd_data,
  output logic rd_valid
);
  import ser_pkg::*;

  localparam logic [15:0] RELOAD = 16'(HALF_DIV - 1);
  localparam logic [15:0] HOLD_AT = 16'(HALF_DIV - 2);
  localparam logic [15:0] CS_RELOAD = 16'(CS_HIGH - 1);

  ser_host_state_t state_reg;
  ser_phase_t phase_reg;
  logic [15:0] cnt_reg;
  logic sck_reg;
  logic cs_n_reg;
  logic si_reg;
  logic hold_n_reg;
  logic hold_rise_reg;
  logic write_reg;
  ser_byte_t addr_reg;
  ser_byte_t tx_reg;
  logic [6:0] rx_reg;
  logic [2:0] bit_reg;
  logic [7:0] left_reg;
  logic busy_reg;
  logic wr_take_reg;
  ser_byte_t rd_data_reg;
  logic rd_valid_reg;
  logic so_s;

  ser_sync3 u_so_sync (
    .clk(core_clk),
    .reset_n(reset_n),
    .din(link.so),
    .dout(so_s)
  );

  logic tick;
  logic rise;
  logic fall;
  logic bit_done;
  logic byte_end;
  logic last_byte;
  logic take_next;
  ser_byte_t byte_in;
  ser_byte_t load_byte;
  ser_byte_t cmd_byte;

  assign tick = cnt_reg == 16'h0000;
  assign rise = tick && !sck_reg;
  assign fall = tick && sck_reg;
  // A bit counts only if hold was released at the rising edge that carried it.
  assign bit_done = fall && hold_rise_reg;
  assign byte_end = bit_done && (bit_reg == `SER_BYTE_LAST);
  assign last_byte = (phase_reg == PH_DATA) && (left_reg == 8'h01);
  assign take_next = write_reg && (phase_reg != PH_INSTR);
  assign byte_in = {rx_reg, so_s};
  assign load_byte = (phase_reg == PH_INSTR) ? addr_reg : (write_reg ? wr_data : `SER_IDLE_BYTE);
  assign cmd_byte = req_write ? `SER_CMD_WRITE : `SER_CMD_READ;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= H_IDLE;
      phase_reg <= PH_INSTR;
      cnt_reg <= 16'h0000;
      sck_reg <= 1'h0;
      cs_n_reg <= 1'h1;
      si_reg <= 1'h0;
      hold_n_reg <= 1'h1;
      hold_rise_reg <= 1'h1;
      write_reg <= 1'h0;
      addr_reg <= 8'h00;
      tx_reg <= 8'h00;
      rx_reg <= 7'h00;
      bit_reg <= `SER_BIT_FIRST;
      left_reg <= 8'h00;
      busy_reg <= 1'h0;
      wr_take_reg <= 1'h0;
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'h0;
    end else begin
      rd_valid_reg <= 1'h0;
      wr_take_reg <= 1'h0;
      case (state_reg)
        H_IDLE: begin
          hold_n_reg <= 1'h1;
          if (req_valid) begin
            state_reg <= H_SHIFT;
            busy_reg <= 1'h1;
            cs_n_reg <= 1'h0;
            write_reg <= req_write;
            addr_reg <= req_addr;
            left_reg <= req_len;
            phase_reg <= PH_INSTR;
            bit_reg <= `SER_BIT_FIRST;
            cnt_reg <= RELOAD;
            tx_reg <= cmd_byte;
            si_reg <= cmd_byte[7];
          end
        end
        H_SHIFT: begin
          cnt_reg <= tick ? RELOAD : cnt_reg - 16'h0001;
          // Hold moves only in the high phase, two cycles after the rise.
          if (sck_reg && !tick && cnt_reg == HOLD_AT) begin
            hold_n_reg <= ~hold_req;
          end
          if (rise) begin
            sck_reg <= 1'h1;
            hold_rise_reg <= hold_n_reg;
          end
          if (fall) begin
            sck_reg <= 1'h0;
          end
          if (bit_done) begin
            bit_reg <= bit_reg + `SER_BIT_STEP;
            rx_reg <= byte_in[6:0];
            tx_reg <= {tx_reg[6:0], 1'h0};
            si_reg <= tx_reg[6];
          end
          if (byte_end) begin
            if (phase_reg == PH_DATA && !write_reg) begin
              rd_data_reg <= byte_in;
              rd_valid_reg <= 1'h1;
            end
            if (phase_reg == PH_DATA) begin
              left_reg <= left_reg - 8'h01;
            end
            if (last_byte) begin
              state_reg <= H_END;
              cs_n_reg <= 1'h1;
              cnt_reg <= CS_RELOAD;
            end else begin
              tx_reg <= load_byte;
              si_reg <= load_byte[7];
              wr_take_reg <= take_next;
              if (phase_reg != PH_DATA) begin
                phase_reg <= (phase_reg == PH_INSTR) ? PH_ADDR : PH_DATA;
              end
            end
          end
        end
        H_END: begin
          cnt_reg <= cnt_reg - 16'h0001;
          if (tick) begin
            state_reg <= H_IDLE;
            busy_reg <= 1'h0;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sck = sck_reg;
  assign link.cs_n = cs_n_reg;
  assign link.si = si_reg;
  assign link.hold_n = hold_n_reg;
  assign busy = busy_reg;
  assign wr_take = wr_take_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
endmodule

// ---- test/ser_link_checker.sv ----
`timescale 1ns/1ns
`include "ser_cfg.svh"
module ser_link_checker #(
  parameter int unsigned WC_CYCLES = 20
) (
  input logic core_clk,
  input logic reset_n,
  input logic cs_n,
  input logic sck,
  input logic si,
  input logic hold_n,
  input logic so_out,
  input logic so_oe,
  input logic write_busy
);
  logic [4:0] bit_cnt_reg;
  logic [7:0] instr_reg;
  logic [15:0] busy_len_reg;
  wire is_read = (instr_reg & `SER_CMD_MASK) == (`SER_CMD_READ & `SER_CMD_MASK);
  wire is_write = (instr_reg & `SER_CMD_MASK) == (`SER_CMD_WRITE & `SER_CMD_MASK);

  // Bits clocked while paused are not counted, so the count matches what the device takes.
  always_ff @(posedge sck or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      bit_cnt_reg <= 5'h00;
      instr_reg <= 8'h00;
    end else if (hold_n) begin
      if (bit_cnt_reg != 5'h1F) bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg < 5'h08) instr_reg <= {instr_reg[6:0], si};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) busy_len_reg <= 16'h0000;
    else busy_len_reg <= write_busy ? busy_len_reg + 16'h0001 : 16'h0000;
  end

  a_so_off_desel: assert property (@(posedge core_clk) disable iff (!reset_n) cs_n |-> !so_oe)
    else $error("output driven while deselected");
  a_busy_no_out: assert property (@(posedge core_clk) disable iff (!reset_n) write_busy |-> !so_oe)
    else $error("array read served during write cycle");
  a_wc_after_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(write_busy) |-> cs_n && $past(cs_n, 2))
    else $error("write cycle started without select rising");
  a_wc_bounded: assert property (@(posedge core_clk) disable iff (!reset_n) busy_len_reg <= WC_CYCLES)
    else $error("write cycle too long");
  a_so_off_hold: assert property (@(posedge sck) disable iff (!reset_n || cs_n) !hold_n |-> !so_oe)
    else $error("output driven while paused");
  a_so_quiet_hdr: assert property (@(posedge sck) disable iff (!reset_n || cs_n)
    bit_cnt_reg < 5'h10 |-> !so_oe)
    else $error("output driven during header");
  a_so_on_read: assert property (@(posedge sck) disable iff (!reset_n || cs_n)
    bit_cnt_reg == 5'h10 && is_read && hold_n && !write_busy |-> so_oe)
    else $error("read data not driven after header");
  a_hold_freeze: assert property (@(posedge sck) disable iff (!reset_n || cs_n)
    !hold_n ##1 !hold_n |-> $stable(so_out))
    else $error("output bit moved while paused");
  a_instr_code: assert property (@(posedge sck) disable iff (!reset_n || cs_n)
    bit_cnt_reg == 5'h08 |-> is_read || is_write)
    else $error("unknown instruction on the wire");

  c_read_hdr: cover property (@(posedge sck) bit_cnt_reg == 5'h10 && is_read && hold_n);
  c_paused: cover property (@(posedge sck) !hold_n ##1 !hold_n);
  c_wc_done: cover property (@(posedge core_clk) $fell(write_busy));
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import ser_pkg::*;
  localparam int unsigned WCC = 200;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic hold_req = 1'b0;
  ser_byte_t req_addr = 8'h00;
  ser_byte_t wr_data = 8'h00;
  logic [7:0] req_len = 8'h01;
  logic busy, rd_valid, write_busy, wr_take;
  ser_byte_t rd_data;
  int n_errors = 0;
  int checks_done = 0;
  int wb_run = 0;
  int wb_last = 0;
  int wb_runs = 0;
  logic [4:0] wcnt;
  logic [15:0] wbits, hdr;

  ser_if link();
  ser_host ser_host_i(.core_clk(core_clk), .reset_n(reset_n), .link(link), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_len(req_len), .wr_data(wr_data), .hold_req(hold_req),
    .busy(busy), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid));
  ser_dev #(.WC_CYCLES(WCC)) ser_dev_i(.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .write_busy(write_busy));
  ser_link_checker #(.WC_CYCLES(WCC)) ser_link_checker_i(.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .hold_n(link.hold_n), .so_out(link.so_out),
    .so_oe(link.so_oe), .write_busy(write_busy));

  initial forever #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (write_busy === 1'b1) wb_run <= wb_run + 1;
    else if (wb_run != 0) begin
      wb_last <= wb_run;
      wb_runs <= wb_runs + 1;
      wb_run <= 0;
    end
  end

  // The header is captured off the wire so bit order is judged independently of either end.
  always @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) wcnt <= 5'h00;
    else if (link.hold_n) begin
      wbits <= {wbits[14:0], link.si};
      wcnt <= wcnt + 5'h01;
      if (wcnt == 5'h0F) hdr <= {wbits[14:0], link.si};
    end
  end

  task automatic xfer(input logic wr, input ser_byte_t a, input logic [7:0] n, input logic [23:0] e,
                      input int hold_at);
    int t;
    int k;
    k = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_len <= n;
    wr_data <= e[7:0];
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (t = 0; t < 3000; t++) begin
      #1;
      if (rd_valid === 1'b1) begin
        `CHK("read byte", rd_data, e[23-8*k -: 8])
        k++;
      end
      // Each consumed write byte pulses once, so writes count bytes like reads do.
      if (wr_take === 1'b1) k++;
      if (busy === 1'b0) break;
      @(posedge core_clk);
      if (t == hold_at) hold_req <= 1'b1;
      if (hold_at >= 0 && t == hold_at + 60) begin
        `CHK("output while paused", link.so_oe, 1'b0)
        hold_req <= 1'b0;
      end
    end
    `CHK("transfer done", busy, 1'b0)
    `CHK("bytes moved", k, int'(n))
    `CHK("output after deselect", link.so_oe, 1'b0)
    `CHK("link clock at rest", link.sck, 1'b0)
  endtask

  task automatic wr_byte(input ser_byte_t a, input ser_byte_t d, input logic probe);
    int t;
    int r0;
    r0 = wb_runs;
    xfer(1'b1, a, 8'h01, {16'h0000, d}, -1);
    if (probe) xfer(1'b0, a, 8'h01, 24'hFF0000, -1);
    for (t = 0; t < 1000 && write_busy !== 1'b0; t++) begin
      @(posedge core_clk);
      #1;
    end
    repeat (10) @(posedge core_clk);
    `CHK("write cycles", wb_runs - r0, 1)
    `CHK("write cycle length", wb_last > 0 && wb_last <= int'(WCC), 1'b1)
    $display("write test at %0h done", a);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    n_errors++;
    close_out;
  end

  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    wr_byte(8'h7E, 8'h12, 1'b1);
    wr_byte(8'h7F, 8'h34, 1'b0);
    wr_byte(8'h00, 8'hC1, 1'b0);
    xfer(1'b0, 8'hFE, 8'h03, 24'h1234C1, -1);
    `CHK("header on wire", hdr, 16'h03FE)
    $display("wrapping read test done");
    xfer(1'b0, 8'h7F, 8'h02, 24'h34C100, 150);
    $display("paused read test done");
    close_out;
  end
endmodule
